// ---- hw/dpd_pkg.sv ----
`default_nettype none
package dpd_pkg;

	// Register indices; byte address is four times the index
	localparam logic [3:0] DPD_IDX_A_FRAC_LOW  = 4'h0;
	localparam logic [3:0] DPD_IDX_A_FRAC_MID  = 4'h1;
	localparam logic [3:0] DPD_IDX_A_RATIO_HI  = 4'h2;
	localparam logic [3:0] DPD_IDX_A_DIV_CTRL  = 4'h3;
	localparam logic [3:0] DPD_IDX_B_FRAC_LOW  = 4'h4;
	localparam logic [3:0] DPD_IDX_B_FRAC_MID  = 4'h5;
	localparam logic [3:0] DPD_IDX_B_RATIO_HI  = 4'h6;
	localparam logic [3:0] DPD_IDX_B_DIV_CTRL  = 4'h7;
	localparam logic [3:0] DPD_IDX_STATUS      = 4'h8;
	localparam int         DPD_NUM_CFG_REGS    = 8;

	localparam int         DPD_REG_W           = 9;
	localparam int         DPD_FRAC_W          = 22;
	localparam int         DPD_INT_W           = 4;
	localparam int         DPD_DIV_W           = 5;

	// Reset values
	localparam logic [8:0] DPD_RST_FRAC_LOW    = 9'h121;
	localparam logic [8:0] DPD_RST_FRAC_MID    = 9'h17e;
	localparam logic [8:0] DPD_RST_RATIO_HI    = 9'h07d;
	localparam logic [8:0] DPD_RST_A_DIV_CTRL  = 9'h010;
	localparam logic [8:0] DPD_RST_B_DIV_CTRL  = 9'h190;

	// Field positions
	localparam int         DPD_POS_INPUT_HALVE = 0;
	localparam int         DPD_POS_DIV_EXTRA   = 1;
	localparam int         DPD_POS_DIV_CODE    = 3;
	localparam int         DPD_POS_INT_MULT    = 4;
	localparam int         DPD_POS_FRAC_HI     = 0;
	localparam int         DPD_FRAC_MID_POS    = 9;
	localparam int         DPD_FRAC_HI_POS     = 18;

	// Output divider factors for codes 00/01/10/11 with extra bit clear
	localparam logic [4:0] DPD_DIV_CODE0       = 5'h02;
	localparam logic [4:0] DPD_DIV_CODE1       = 5'h04;
	localparam logic [4:0] DPD_DIV_CODE2       = 5'h08;
	localparam logic [4:0] DPD_DIV_CODE3       = 5'h0c;
	localparam logic [4:0] DPD_RST_DIV         = 5'h08;

	typedef enum logic {
		DPD_MODE_USER,
		DPD_MODE_RECEIVER
	} dpd_mode_e;

	typedef struct packed {
		logic        input_halve;
		logic [3:0]  integer_mult;
		logic [21:0] fraction_mult;
		logic [1:0]  out_div_code;
		logic        out_div_extra;
		logic [4:0]  out_divisor;
	} dpd_synth_cfg_s;

	typedef struct packed {
		logic [3:0]  integer_mult;
		logic [21:0] fraction_mult;
		logic [1:0]  out_div_code;
	} dpd_rx_ctrl_s;

endpackage

`default_nettype wire

// ---- hw/dpd_synth_ctrl.sv ----
// Notes on behaviour
// - Each synthesiser ratio is the integer multiplier plus the fractional multiplier.
// - Fraction field is floor(2^22 times fractional remainder), read as fraction of one.
// - Bit 0 of each divider control register halves the oscillator input when set.
// - User mode divider: codes 00..11 give 2/4/8/12, doubled when post-scale set.
// - User mode takes all settings from software; receiver drives A's multipliers and code.
// - Receiver mode: A post-scale picks 256fs or 128fs; B's code and post-scale ignored.
// - B's integer multiplier sits in bits 7:4 of its third register, reset 0111.
// - The 22-bit fraction spans three registers: 9 bits, 9 bits, low nibble.
// - Receiver mode while the receiver is enabled, user mode while it is disabled.
`timescale 1ns/1ns
`default_nettype none

module dpd_synth_ctrl
	import dpd_pkg::*;
(
	input  wire logic           mclk_i,
	input  wire logic           rst_n_i,
	input  wire logic           wb_cyc_i,
	input  wire logic           wb_stb_i,
	input  wire logic           wb_we_i,
	input  wire logic [7:0]     wb_adr_i,
	input  wire logic [3:0]     wb_sel_i,
	input  wire logic [31:0]    wb_dat_i,
	output logic      [31:0]    wb_dat_o,
	output logic                wb_ack_o,
	input  wire logic           rx_enable_i,
	input  wire dpd_rx_ctrl_s   rx_ctrl_i,
	output dpd_synth_cfg_s      synth_a_cfg_o,
	output dpd_synth_cfg_s      synth_b_cfg_o,
	output logic                synth_a_output_clock_o,
	output logic                synth_b_output_clock_o,
	output logic                receiver_mode_o
);

	// Output divider factor from code and extra bit
	function automatic logic [4:0] div_of(input logic [1:0] code, input logic extra);
		logic [4:0] base;
		base = DPD_DIV_CODE0;
		case (code)
			2'b00: base = DPD_DIV_CODE0;
			2'b01: base = DPD_DIV_CODE1;
			2'b10: base = DPD_DIV_CODE2;
			2'b11: base = DPD_DIV_CODE3;
			default: base = DPD_DIV_CODE0;
		endcase
		div_of = extra ? 5'(base << 1) : base;
	endfunction

	// Assemble the configuration of one synthesiser from its four registers
	function automatic dpd_synth_cfg_s cfg_of(input logic [8:0] lo, input logic [8:0] mid,
	                                          input logic [8:0] hi, input logic [8:0] ctl);
		dpd_synth_cfg_s c;
		c.input_halve   = ctl[DPD_POS_INPUT_HALVE];
		c.integer_mult  = hi[DPD_POS_INT_MULT +: DPD_INT_W];
		c.fraction_mult = {hi[DPD_POS_FRAC_HI +: 4], mid, lo};
		c.out_div_code  = ctl[DPD_POS_DIV_CODE +: 2];
		c.out_div_extra = ctl[DPD_POS_DIV_EXTRA];
		c.out_divisor   = div_of(c.out_div_code, c.out_div_extra);
		cfg_of = c;
	endfunction

	function automatic logic [8:0] rst_of(input int idx);
		logic [8:0] v;
		v = DPD_RST_FRAC_LOW;
		case (idx)
			0, 4:    v = DPD_RST_FRAC_LOW;
			1, 5:    v = DPD_RST_FRAC_MID;
			2, 6:    v = DPD_RST_RATIO_HI;
			3:       v = DPD_RST_A_DIV_CTRL;
			7:       v = DPD_RST_B_DIV_CTRL;
			default: v = DPD_RST_FRAC_LOW;
		endcase
		rst_of = v;
	endfunction

	// Divider count has reached the last step of the current factor
	function automatic logic at_wrap(input logic [4:0] cnt, input logic [4:0] div);
		at_wrap = (cnt >= 5'(div - 5'h01));
	endfunction

	// Divided clock is high for the first half of each count
	function automatic logic high_half(input logic [4:0] cnt, input logic [4:0] div);
		high_half = (cnt < (div >> 1));
	endfunction

	// Status word: A and B divisors in use, B stopped, receiver mode
	function automatic logic [31:0] status_of(input logic [4:0] a_div, input logic [4:0] b_div,
	                                          input logic b_stop, input logic rx_on);
		logic [31:0] s;
		s         = 32'h0000_0000;
		s[15:11]  = a_div;
		s[10:6]   = b_div;
		s[1]      = b_stop;
		s[0]      = rx_on;
		status_of = s;
	endfunction

	// Settings shown on the outputs while reset is held
	localparam dpd_synth_cfg_s A_RST_CFG = cfg_of(DPD_RST_FRAC_LOW, DPD_RST_FRAC_MID, DPD_RST_RATIO_HI,
	                                              DPD_RST_A_DIV_CTRL);
	localparam dpd_synth_cfg_s B_RST_CFG = cfg_of(DPD_RST_FRAC_LOW, DPD_RST_FRAC_MID, DPD_RST_RATIO_HI,
	                                              DPD_RST_B_DIV_CTRL);

	logic [8:0]      regs_q [DPD_NUM_CFG_REGS];
	logic            ack_q;
	logic [31:0]     rdata_q;
	dpd_mode_e       mode_q;
	dpd_synth_cfg_s  a_sw;
	dpd_synth_cfg_s  b_sw;
	dpd_synth_cfg_s  a_eff;
	dpd_synth_cfg_s  b_eff;
	dpd_synth_cfg_s  a_cfg_q;
	dpd_synth_cfg_s  b_cfg_q;
	logic [4:0]      a_cnt_q;
	logic [4:0]      a_div_q;
	logic [4:0]      b_cnt_q;
	logic [4:0]      b_div_q;
	logic            a_clk_q;
	logic            b_clk_q;
	logic            bus_req;
	logic            bus_wr;
	logic [3:0]      bus_idx;
	logic            idx_mapped;
	logic [31:0]     rdata_d;
	logic            cfg_hit;
	logic            wr_lo;
	logic            wr_hi;
	logic            rx_mode;
	logic            b_stopped;
	logic            a_wrap;
	logic            b_wrap;

	// Wishbone decode: word aligned, index in bits 5:2, upper address bits must be zero
	assign bus_req    = wb_cyc_i && wb_stb_i && !ack_q;
	assign bus_wr     = bus_req && wb_we_i;
	assign bus_idx    = wb_adr_i[5:2];
	assign idx_mapped = (wb_adr_i[7:6] == 2'b00) && (wb_adr_i[1:0] == 2'b00)
	                    && (bus_idx <= DPD_IDX_STATUS);
	assign cfg_hit    = idx_mapped && (bus_idx < DPD_IDX_STATUS);

	// Byte lane 0 carries bits 7:0, lane 1 carries bit 8
	assign wr_lo      = bus_wr && cfg_hit && wb_sel_i[0];
	assign wr_hi      = bus_wr && cfg_hit && wb_sel_i[1];

	// Single-wait acknowledge, dropped the cycle after it is given
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= bus_req;
		end
	end

	// Configuration register writes honour byte lanes 0 and 1
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < DPD_NUM_CFG_REGS; i++) begin
				regs_q[i] <= rst_of(i);
			end
		end else begin
			if (wr_lo) begin
				regs_q[bus_idx[2:0]][7:0] <= wb_dat_i[7:0];
			end
			if (wr_hi) begin
				regs_q[bus_idx[2:0]][8] <= wb_dat_i[8];
			end
		end
	end

	// Read data: stored values, status word, zero for unmapped addresses
	always_comb begin
		rdata_d = 32'h0000_0000;
		if (cfg_hit) begin
			rdata_d = {23'h000000, regs_q[bus_idx[2:0]]};
		end else if (idx_mapped) begin
			rdata_d = status_of(a_div_q, b_div_q, b_stopped, rx_mode);
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_q <= 32'h0000_0000;
		end else if (bus_req) begin
			rdata_q <= rdata_d;
		end
	end

	assign wb_dat_o = rdata_q;
	assign wb_ack_o = ack_q;

	// Operating mode follows the receiver enable
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mode_q <= DPD_MODE_USER;
		end else begin
			mode_q <= rx_enable_i ? DPD_MODE_RECEIVER : DPD_MODE_USER;
		end
	end

	// B reports stopped once its clock is held low in receiver mode
	assign rx_mode   = (mode_q == DPD_MODE_RECEIVER);
	assign b_stopped = rx_mode && !b_clk_q;

	assign a_sw = cfg_of(regs_q[DPD_IDX_A_FRAC_LOW[2:0]], regs_q[DPD_IDX_A_FRAC_MID[2:0]],
	                     regs_q[DPD_IDX_A_RATIO_HI[2:0]], regs_q[DPD_IDX_A_DIV_CTRL[2:0]]);
	assign b_sw = cfg_of(regs_q[DPD_IDX_B_FRAC_LOW[2:0]], regs_q[DPD_IDX_B_FRAC_MID[2:0]],
	                     regs_q[DPD_IDX_B_RATIO_HI[2:0]], regs_q[DPD_IDX_B_DIV_CTRL[2:0]]);

	// Effective settings: receiver overrides A's multipliers and code; A's extra bit
	// keeps doubling the divider, giving 128fs instead of 256fs
	always_comb begin
		a_eff = a_sw;
		b_eff = b_sw;
		if (mode_q == DPD_MODE_RECEIVER) begin
			a_eff.integer_mult  = rx_ctrl_i.integer_mult;
			a_eff.fraction_mult = rx_ctrl_i.fraction_mult;
			a_eff.out_div_code  = rx_ctrl_i.out_div_code;
			a_eff.out_divisor   = div_of(rx_ctrl_i.out_div_code, a_sw.out_div_extra);
			b_eff.out_div_code  = 2'b00;
			b_eff.out_div_extra = 1'b0;
			b_eff.out_divisor   = b_div_q;
		end
	end

	// Ratio handed to each loop is {integer, fraction} as a fixed-point value N + K/2^22
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			a_cfg_q <= A_RST_CFG;
		end else begin
			a_cfg_q <= a_eff;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			b_cfg_q <= B_RST_CFG;
		end else begin
			b_cfg_q <= b_eff;
		end
	end

	assign synth_a_cfg_o   = a_cfg_q;
	assign synth_b_cfg_o   = b_cfg_q;
	assign receiver_mode_o = (mode_q == DPD_MODE_RECEIVER);

	// Wrap points of both dividers
	assign a_wrap = at_wrap(a_cnt_q, a_div_q);
	assign b_wrap = at_wrap(b_cnt_q, b_div_q);

	// Divider A: new factor is taken only when the count wraps
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			a_cnt_q <= 5'h00;
			a_div_q <= DPD_RST_DIV;
		end else if (a_wrap) begin
			a_cnt_q <= 5'h00;
			a_div_q <= a_eff.out_divisor;
		end else begin
			a_cnt_q <= 5'(a_cnt_q + 5'h01);
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			a_clk_q <= 1'b0;
		end else begin
			a_clk_q <= high_half(a_cnt_q, a_div_q);
		end
	end

	// Divider B stops low in receiver mode, its clock is not available there
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			b_cnt_q <= 5'h00;
			b_div_q <= DPD_RST_DIV;
		end else if (mode_q == DPD_MODE_RECEIVER) begin
			b_cnt_q <= 5'h00;
		end else if (b_wrap) begin
			b_cnt_q <= 5'h00;
			b_div_q <= b_eff.out_divisor;
		end else begin
			b_cnt_q <= 5'(b_cnt_q + 5'h01);
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			b_clk_q <= 1'b0;
		end else if (mode_q == DPD_MODE_RECEIVER) begin
			b_clk_q <= 1'b0;
		end else begin
			b_clk_q <= high_half(b_cnt_q, b_div_q);
		end
	end

	assign synth_a_output_clock_o = a_clk_q;
	assign synth_b_output_clock_o = b_clk_q;

endmodule // dpd_synth_ctrl

`default_nettype wire

// ---- verif/dpd_synth_ctrl_assertions.sv ----
`timescale 1ns/1ns
`default_nettype none
module dpd_synth_ctrl_assertions
	import dpd_pkg::*;
(
	input wire logic           mclk_i,
	input wire logic           rst_n_i,
	input wire logic           wb_cyc_i,
	input wire logic           wb_stb_i,
	input wire logic           wb_we_i,
	input wire logic [7:0]     wb_adr_i,
	input wire logic [31:0]    wb_dat_o,
	input wire logic           wb_ack_o,
	input wire logic           rx_enable_i,
	input wire dpd_rx_ctrl_s   rx_ctrl_i,
	input wire dpd_synth_cfg_s synth_a_cfg_o,
	input wire logic           synth_b_output_clock_o,
	input wire logic           receiver_mode_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	function automatic logic [4:0] div_of(input logic [1:0] c, input logic e);
		logic [4:0] b;
		b = (c == 2'h0) ? DPD_DIV_CODE0 : (c == 2'h1) ? DPD_DIV_CODE1 : (c == 2'h2) ? DPD_DIV_CODE2 : DPD_DIV_CODE3;
		return b << e;
	endfunction
	sequence req_s;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence odd_rd_s;
		req_s ##0 (!wb_we_i && wb_adr_i[7:6] != 2'h0);
	endsequence
	ack_timing_a: assert property (req_s |=> wb_ack_o) else $error("ack missing");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	unmapped_zero_a: assert property (odd_rd_s |=> wb_ack_o && wb_dat_o == 32'h0) else $error("unmapped read");
	reg_width_a: assert property (wb_ack_o && wb_adr_i[5:2] != 4'h8 |-> wb_dat_o[31:9] == 23'h0)
		else $error("upper read bits set");
	mode_on_a: assert property (rx_enable_i |=> receiver_mode_o) else $error("mode not entered");
	mode_off_a: assert property (!rx_enable_i |=> !receiver_mode_o) else $error("mode not left");
	rx_override_a: assert property (receiver_mode_o |=>
		{synth_a_cfg_o.integer_mult, synth_a_cfg_o.fraction_mult, synth_a_cfg_o.out_div_code} == $past(rx_ctrl_i))
		else $error("receiver fields not applied");
	b_stopped_a: assert property (receiver_mode_o |=> !synth_b_output_clock_o) else $error("B clock runs");
	a_divisor_a: assert property (synth_a_cfg_o.out_divisor ==
		div_of(synth_a_cfg_o.out_div_code, synth_a_cfg_o.out_div_extra)) else $error("A divisor wrong");
endmodule // dpd_synth_ctrl_assertions
bind dpd_synth_ctrl dpd_synth_ctrl_assertions dpd_synth_ctrl_assertions_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .rx_enable_i(rx_enable_i), .rx_ctrl_i(rx_ctrl_i), .synth_a_cfg_o(synth_a_cfg_o),
	.synth_b_output_clock_o(synth_b_output_clock_o), .receiver_mode_o(receiver_mode_o));
`default_nettype wire

// ---- verif/tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb;
	import dpd_pkg::*;
	logic           mclk_i = 1'b0;
	logic           rst_n_i = 1'b0;
	logic           wb_cyc_i = 1'b0;
	logic           wb_stb_i = 1'b0;
	logic           wb_we_i = 1'b0;
	logic [7:0]     wb_adr_i = 8'h00;
	logic [3:0]     wb_sel_i = 4'h3;
	logic [31:0]    wb_dat_i = 32'h0;
	logic [31:0]    wb_dat_o;
	logic           wb_ack_o;
	logic           rx_enable_i = 1'b0;
	dpd_rx_ctrl_s   rx_ctrl_i = '0;
	dpd_synth_cfg_s synth_a_cfg_o;
	dpd_synth_cfg_s synth_b_cfg_o;
	logic           synth_a_output_clock_o;
	logic           synth_b_output_clock_o;
	logic           receiver_mode_o;
	int             bad_count = 0;
	int             samples_checked = 0;
	int             ra;
	int             rb;
	logic           pa;
	logic           pb;
	logic [31:0]    rd;
	logic [4:0]     base [4] = '{5'h02, 5'h04, 5'h08, 5'h0c};
	dpd_synth_ctrl dpd_synth_ctrl_inst (.mclk_i, .rst_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .rx_enable_i, .rx_ctrl_i, .synth_a_cfg_o, .synth_b_cfg_o,
		.synth_a_output_clock_o, .synth_b_output_clock_o, .receiver_mode_o);
	initial forever #4 mclk_i = ~mclk_i;
	task automatic tick(input int n);
		repeat (n) @(posedge mclk_i);
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Classic single cycle; held until ack is sampled high, the watchdog ends a lost answer
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
		@(posedge mclk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= wd;
		do begin
			@(posedge mclk_i);
		end while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic rdchk(input logic [3:0] idx, input logic [31:0] exp);
		wb(1'b0, {2'h0, idx, 2'h0}, 32'h0);
		check(rd, exp);
	endtask
	task automatic wr(input logic [3:0] idx, input logic [8:0] d);
		wb(1'b1, {2'h0, idx, 2'h0}, {23'h0, d});
	endtask
	task automatic report_and_stop;
		$display("Comparisons %0d, mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		tick(5000);
		bad_count++;
		report_and_stop;
	end
	initial begin
		tick(3);
		rst_n_i <= 1'b1;
		rdchk(DPD_IDX_B_RATIO_HI, 32'h07d);
		rdchk(DPD_IDX_A_DIV_CTRL, 32'h010);
		rdchk(DPD_IDX_B_DIV_CTRL, 32'h190);
		wb(1'b0, 8'h41, 32'h0);
		check(rd, 32'h0);
		wr(DPD_IDX_B_FRAC_LOW, 9'h1ba);
		wr(DPD_IDX_B_FRAC_MID, 9'h024);
		wr(DPD_IDX_B_RATIO_HI, 9'h083);
		tick(2);
		check(32'(synth_b_cfg_o.fraction_mult), 32'h0c49ba);
		check(32'(synth_b_cfg_o.integer_mult), 32'h8);
		for (int c = 0; c < 4; c++) begin
			for (int e = 0; e < 2; e++) begin
				wr(DPD_IDX_A_DIV_CTRL, 9'((c << 3) | (e << 1) | e));
				tick(2);
				check(32'(synth_a_cfg_o.out_divisor), 32'(base[c] << e));
				check(32'(synth_a_cfg_o.input_halve), 32'(e));
				check(32'(synth_a_cfg_o.out_div_extra), 32'(e));
			end
		end
		// A divides by 24, B by 8: count rising edges over 96 cycles
		tick(30);
		ra = 0;
		rb = 0;
		pa = synth_a_output_clock_o;
		pb = synth_b_output_clock_o;
		repeat (96) begin
			@(posedge mclk_i);
			if (synth_a_output_clock_o && !pa) ra++;
			if (synth_b_output_clock_o && !pb) rb++;
			pa = synth_a_output_clock_o;
			pb = synth_b_output_clock_o;
		end
		check(32'(ra), 32'h4);
		check(32'(rb), 32'hc);
		wr(DPD_IDX_A_DIV_CTRL, 9'h002);
		rx_ctrl_i <= {4'h9, 22'h2c2b24, 2'h3};
		rx_enable_i <= 1'b1;
		tick(3);
		check(32'(synth_a_cfg_o.integer_mult), 32'h9);
		check(32'(synth_a_cfg_o.fraction_mult), 32'h2c2b24);
		check(32'(synth_a_cfg_o.out_divisor), 32'h18);
		check(32'(synth_a_cfg_o.out_div_code), 32'h3);
		check(32'(synth_a_cfg_o.input_halve), 32'h0);
		check(32'(synth_b_cfg_o.integer_mult), 32'h8);
		// Let divider A pass a wrap so the status shows the receiver factor
		tick(30);
		rdchk(DPD_IDX_STATUS, 32'hc203);
		rb = 0;
		repeat (16) begin
			@(posedge mclk_i);
			if (synth_b_output_clock_o !== 1'b0) rb++;
		end
		check(32'(rb), 32'h0);
		wr(DPD_IDX_A_DIV_CTRL, 9'h000);
		tick(2);
		check(32'(synth_a_cfg_o.out_divisor), 32'h0c);
		rx_enable_i <= 1'b0;
		tick(3);
		check(32'(synth_a_cfg_o.integer_mult), 32'h7);
		// Byte lanes: lane 0 writes bits 7:0, lane 1 writes bit 8
		wb_sel_i <= 4'h1;
		wr(DPD_IDX_B_FRAC_LOW, 9'h0ff);
		rdchk(DPD_IDX_B_FRAC_LOW, 32'h1ff);
		wb_sel_i <= 4'h2;
		wr(DPD_IDX_B_FRAC_LOW, 9'h000);
		wb_sel_i <= 4'h3;
		rdchk(DPD_IDX_B_FRAC_LOW, 32'h0ff);
		report_and_stop;
	end
endmodule // tb
`default_nettype wire
